/* File: design/node_image_pkg.sv */
package node_image_pkg;
  // acyclic request queue depth
  localparam int ACYC_DEPTH = 10;
  localparam int ACYC_CNT_W = 4;
  // field widths
  localparam int NODE_W = 8;
  localparam int CKSUM_W = 16;
  localparam int REQ_W = 32;
  // reset values
  localparam logic [NODE_W-1:0] NODE_RESET = 8'h00;
  localparam logic [CKSUM_W-1:0] CKSUM_RESET = 16'h0000;
  // avalon register word offsets (byte address = 4 * index)
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h1;
  localparam logic [3:0] REG_IRQ_STAT = 4'h2;
  localparam logic [3:0] REG_IRQ_MASK = 4'h3;
  localparam logic [3:0] REG_REQ_DATA = 4'h4;
  localparam logic [3:0] REG_REQ_LEVEL = 4'h5;
  localparam logic [3:0] REG_CKSUM = 4'h6;
  // status word bit positions
  localparam int ST_LIVE = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_ALARM = 2;
  localparam int ST_DIAG = 3;
  localparam int ST_ADDR = 4;
  localparam int ST_CKSUM = 5;
  localparam int ST_CLEAR = 6;
  localparam int ST_ACK = 7;
  localparam int ST_NODE = 8;
  // control word bit positions
  localparam int CT_RAISE = 0;
  localparam int CT_NODE = 8;
  // interrupt bit positions
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_ALARM = 1;
  localparam int IRQ_DIAG = 2;
  localparam int IRQ_ACK = 3;
  localparam int IRQ_W = 4;
endpackage

/* File: design/node_image_if.sv */
`timescale 1ns/1ps
interface node_image_if;
  import node_image_pkg::*;
  // status image, device to host
  logic cyclic_link_live;
  logic node_fault_flag;
  logic unloaded_alarm_waiting;
  logic diag_waiting_flag;
  logic station_addr_conflict;
  logic layout_checksum_conflict;
  logic clear_state_indicator;
  logic alarm_ack_status;
  logic [NODE_W-1:0] node_number;
  logic [CKSUM_W-1:0] layout_checksum;
  // control image, host to device
  logic [NODE_W-1:0] ctrl_node_number;
  logic alarm_raise_request;
  logic [CKSUM_W-1:0] ctrl_layout_checksum;
  // acyclic request path
  logic req_valid;
  logic req_ready;
  logic [REQ_W-1:0] req_data;
  modport device (
    output cyclic_link_live, node_fault_flag, unloaded_alarm_waiting,
    output diag_waiting_flag, station_addr_conflict,
    output layout_checksum_conflict, clear_state_indicator,
    output alarm_ack_status, node_number, layout_checksum, req_ready,
    input ctrl_node_number, alarm_raise_request, ctrl_layout_checksum,
    input req_valid, req_data
  );
  modport host (
    input cyclic_link_live, node_fault_flag, unloaded_alarm_waiting,
    input diag_waiting_flag, station_addr_conflict,
    input layout_checksum_conflict, clear_state_indicator,
    input alarm_ack_status, node_number, layout_checksum, req_ready,
    output ctrl_node_number, alarm_raise_request, ctrl_layout_checksum,
    output req_valid, req_data
  );
endinterface

/* File: design/node_image_device.sv */
`timescale 1ns/1ps
// Behaviour
// - fault flag clears on valid station response
// - alarm waiting flag follows pending alarm
// - diag waiting flag follows pending diagnostics
// - address conflict when actual differs from written
// - checksum conflict when output mapping disagrees
// - clear indicator low means clear mode
// - ack status low once alarm acknowledged
// - alarm sent only on raise rising edge
// - hold up to ten acyclic requests
// - acyclic service only while link live
// - only cyclic master issues acyclic service
// - host writes expected node number
// - report node checksum and node number
// - live flag gates use of input data
// - fault on ident, link fault, size mismatch
module node_image_device
  import node_image_pkg::*;
(
  input wire logic ref_clk, // module clock
  input wire logic rst, // sync reset, high
  node_image_if.device img, // status and control image
  input wire logic slave_mode, // emulating slaves
  input wire logic link_live, // configured and exchanging
  input wire logic valid_response, // valid reply from station
  input wire logic ident_mismatch, // ident bad at parameterization
  input wire logic link_fault, // data link fault reply
  input wire logic size_mismatch, // cyclic size differs
  input wire logic alarm_pending, // alarm to unload
  input wire logic diag_pending, // diagnostics to unload
  input wire logic [NODE_W-1:0] actual_node, // actual station address
  input wire logic [CKSUM_W-1:0] computed_cksum, // computed mapping sum
  input wire logic clear_mode, // master put slave in clear
  input wire logic alarm_acked, // master acknowledged alarm
  input wire logic requester_is_cyclic, // request from cyclic master
  output logic alarm_notify, // one pulse alarm to master
  output logic svc_valid, // acyclic service issued
  output logic [REQ_W-1:0] svc_data, // service request word
  input wire logic svc_done, // service finished
  output logic svc_refused, // request dropped, not live or requester not cyclic
  output logic [ACYC_CNT_W-1:0] queue_level // held requests
);
  logic fault_reg;
  logic raise_d_reg;
  logic alarm_open_reg;
  logic ack_reg;
  logic [REQ_W-1:0] queue_reg [ACYC_DEPTH];
  logic [ACYC_CNT_W-1:0] rd_reg, wr_reg, cnt_reg;
  logic svc_busy_reg;
  logic [REQ_W-1:0] svc_data_reg;
  logic refused_reg;
  logic push, pop, raise_edge;

  function automatic logic [ACYC_CNT_W-1:0] wrap_inc(
    input logic [ACYC_CNT_W-1:0] p);
    wrap_inc = (p == ACYC_CNT_W'(ACYC_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // head dropped when link down or requester not cyclic master
  function automatic logic refused_next();
    refused_next = !svc_busy_reg && (cnt_reg != '0)
      && !(link_live && requester_is_cyclic);
  endfunction

  // fault flag, set wins over clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fault_reg <= 1'b0;
    end else if (ident_mismatch || link_fault || size_mismatch) begin
      fault_reg <= 1'b1;
    end else if (valid_response) begin
      fault_reg <= 1'b0;
    end
  end

  // alarm raise edge detect and ack tracking
  assign raise_edge = img.alarm_raise_request && !raise_d_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      raise_d_reg <= 1'b0;
      alarm_open_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      raise_d_reg <= img.alarm_raise_request;
      if (slave_mode && raise_edge) begin
        alarm_open_reg <= 1'b1;
        ack_reg <= 1'b0;
      end else if (alarm_open_reg && alarm_acked) begin
        alarm_open_reg <= 1'b0;
        ack_reg <= 1'b1;
      end
    end
  end

  // one cycle notification pulse
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alarm_notify <= 1'b0;
    end else begin
      alarm_notify <= slave_mode && raise_edge;
    end
  end

  // request queue, ten entries
  assign push = img.req_valid && img.req_ready;
  assign pop = svc_busy_reg && svc_done;
  assign img.req_ready = (cnt_reg != ACYC_CNT_W'(ACYC_DEPTH));
  always_ff @(posedge ref_clk) begin
    if (push) begin
      queue_reg[wr_reg] <= img.req_data;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wrap_inc(wr_reg);
      end
      if (pop || refused_next()) begin
        rd_reg <= wrap_inc(rd_reg);
      end
      cnt_reg <= cnt_reg + ACYC_CNT_W'(push)
        - ACYC_CNT_W'(pop || refused_next());
    end
  end

  // service issue, only while link live
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      svc_busy_reg <= 1'b0;
      svc_data_reg <= '0;
      refused_reg <= 1'b0;
    end else begin
      refused_reg <= refused_next();
      if (pop) begin
        svc_busy_reg <= 1'b0;
      end else if (!svc_busy_reg && cnt_reg != '0 && link_live
                   && requester_is_cyclic) begin
        svc_busy_reg <= 1'b1;
        svc_data_reg <= queue_reg[rd_reg];
      end
    end
  end

  // status image drive
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      img.cyclic_link_live <= 1'b0;
      img.unloaded_alarm_waiting <= 1'b0;
      img.diag_waiting_flag <= 1'b0;
      img.station_addr_conflict <= 1'b0;
      img.layout_checksum_conflict <= 1'b0;
      img.clear_state_indicator <= 1'b1;
      img.node_number <= NODE_RESET;
      img.layout_checksum <= CKSUM_RESET;
    end else begin
      img.cyclic_link_live <= link_live;
      img.unloaded_alarm_waiting <= alarm_pending;
      img.diag_waiting_flag <= diag_pending;
      img.station_addr_conflict <=
        (actual_node != img.ctrl_node_number);
      img.layout_checksum_conflict <=
        (img.ctrl_layout_checksum != computed_cksum);
      img.clear_state_indicator <= !(slave_mode && clear_mode);
      img.node_number <= actual_node;
      img.layout_checksum <= computed_cksum;
    end
  end

  assign img.node_fault_flag = fault_reg;
  assign img.alarm_ack_status = !(slave_mode && ack_reg);
  assign svc_valid = svc_busy_reg;
  assign svc_data = svc_data_reg;
  assign svc_refused = refused_reg;
  assign queue_level = cnt_reg;
endmodule

/* File: design/node_image_host.sv */
`timescale 1ns/1ps
module node_image_host
  import node_image_pkg::*;
(
  input wire logic ref_clk, // module clock
  input wire logic rst, // sync reset, high
  node_image_if.host img, // status and control image
  input wire logic [3:0] avs_address, // word address
  input wire logic avs_read, // read strobe
  input wire logic avs_write, // write strobe
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  output logic irq // level interrupt
);
  logic [31:0] ctrl_reg;
  logic [CKSUM_W-1:0] cksum_reg;
  logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg, ev;
  logic [REQ_W-1:0] req_reg;
  logic req_v_reg;
  logic done_reg;
  logic fault_d_reg, alarm_d_reg, diag_d_reg, ack_d_reg;
  logic wr_hit, stall;

  // one cycle wait on every access, request push may stall
  assign stall = avs_write && avs_address == REG_REQ_DATA && req_v_reg;
  assign avs_waitrequest = (avs_read || avs_write) && (!done_reg || stall);
  assign wr_hit = avs_write && !avs_waitrequest;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (avs_read || avs_write) && !done_reg && !stall;
    end
  end

  // control and checksum registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg <= '0;
      cksum_reg <= CKSUM_RESET;
      irq_mask_reg <= '0;
    end else if (wr_hit) begin
      if (avs_address == REG_CTRL) ctrl_reg <= avs_writedata;
      if (avs_address == REG_CKSUM) cksum_reg <= avs_writedata[15:0];
      if (avs_address == REG_IRQ_MASK) irq_mask_reg <= avs_writedata[3:0];
    end
  end

  // request push to device queue
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_v_reg <= 1'b0;
      req_reg <= '0;
    end else if (wr_hit && avs_address == REG_REQ_DATA) begin
      req_v_reg <= 1'b1;
      req_reg <= avs_writedata;
    end else if (img.req_ready) begin
      req_v_reg <= 1'b0;
    end
  end

  // rising edges of status flags, falling edge of ack status, set wins over clear
  assign ev = {img.alarm_ack_status == 1'b0 && ack_d_reg,
               img.diag_waiting_flag && !diag_d_reg,
               img.unloaded_alarm_waiting && !alarm_d_reg,
               img.node_fault_flag && !fault_d_reg};
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fault_d_reg <= 1'b0;
      alarm_d_reg <= 1'b0;
      diag_d_reg <= 1'b0;
      ack_d_reg <= 1'b1;
      irq_stat_reg <= '0;
    end else begin
      fault_d_reg <= img.node_fault_flag;
      alarm_d_reg <= img.unloaded_alarm_waiting;
      diag_d_reg <= img.diag_waiting_flag;
      ack_d_reg <= img.alarm_ack_status;
      if (wr_hit && avs_address == REG_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~avs_writedata[3:0]) | ev;
      end else begin
        irq_stat_reg <= irq_stat_reg | ev;
      end
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // read mux, live flag reported for data gating
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      avs_readdata <= '0;
    end else begin
      unique case (avs_address)
        REG_STATUS: avs_readdata <= {16'h0000, img.node_number,
          img.alarm_ack_status, img.clear_state_indicator,
          img.layout_checksum_conflict, img.station_addr_conflict,
          img.diag_waiting_flag, img.unloaded_alarm_waiting,
          img.node_fault_flag, img.cyclic_link_live};
        REG_CTRL: avs_readdata <= ctrl_reg;
        REG_IRQ_STAT: avs_readdata <= {28'h0000000, irq_stat_reg};
        REG_IRQ_MASK: avs_readdata <= {28'h0000000, irq_mask_reg};
        REG_REQ_DATA: avs_readdata <= req_reg;
        REG_REQ_LEVEL: avs_readdata <= {31'h00000000, req_v_reg};
        REG_CKSUM: avs_readdata <= {16'h0000, img.layout_checksum};
        default: avs_readdata <= '0;
      endcase
    end
  end

  assign img.ctrl_node_number = ctrl_reg[CT_NODE +: NODE_W];
  assign img.alarm_raise_request = ctrl_reg[CT_RAISE];
  assign img.ctrl_layout_checksum = cksum_reg;
  assign img.req_valid = req_v_reg;
  assign img.req_data = req_reg;
endmodule

/* File: bench/node_image_props.sv */
`timescale 1ns/1ps
// watches the status image against its causes
module node_image_props
  import node_image_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic slave_mode, // in
  input wire logic link_live, // in
  input wire logic valid_response, // in
  input wire logic ident_mismatch, // in
  input wire logic link_fault, // in
  input wire logic size_mismatch, // in
  input wire logic alarm_pending, // in
  input wire logic diag_pending, // in
  input wire logic clear_mode, // in
  input wire logic alarm_notify, // out
  input wire logic cyclic_link_live, // out
  input wire logic node_fault_flag, // out
  input wire logic unloaded_alarm_waiting, // out
  input wire logic diag_waiting_flag, // out
  input wire logic station_addr_conflict, // out
  input wire logic clear_state_indicator, // out
  input wire logic [NODE_W-1:0] node_number, // out
  input wire logic [NODE_W-1:0] ctrl_node_number, // host
  input wire logic alarm_raise_request // host
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // host raise bit going from low to high in slave mode
  sequence s_raise;
    !alarm_raise_request ##1 slave_mode && alarm_raise_request;
  endsequence
  property p_live;
    1'b1 |=> cyclic_link_live == $past(link_live);
  endproperty
  property p_fault_set;
    ident_mismatch || link_fault || size_mismatch |=> node_fault_flag;
  endproperty
  property p_fault_clr;
    valid_response && !(ident_mismatch || link_fault || size_mismatch)
      |=> !node_fault_flag;
  endproperty
  property p_alarm;
    1'b1 |=> unloaded_alarm_waiting == $past(alarm_pending);
  endproperty
  property p_diag;
    !diag_pending [*2] |-> !diag_waiting_flag;
  endproperty
  property p_addr;
    1'b1 |=> station_addr_conflict ==
      (node_number != $past(ctrl_node_number));
  endproperty
  property p_clear;
    slave_mode && clear_mode |=> !clear_state_indicator;
  endproperty
  property p_notify;
    s_raise |=> alarm_notify;
  endproperty
  property p_notify_src;
    alarm_notify |-> $past(alarm_raise_request) &&
      !$past(alarm_raise_request, 2);
  endproperty
  a_live: assert property (p_live)
    else $error("live flag wrong");
  a_fault_set: assert property (p_fault_set)
    else $error("fault unset");
  a_fault_clr: assert property (p_fault_clr)
    else $error("fault stuck");
  a_alarm: assert property (p_alarm)
    else $error("alarm flag wrong");
  a_diag: assert property (p_diag)
    else $error("diag flag stuck");
  a_addr: assert property (p_addr)
    else $error("addr conflict wrong");
  a_clear: assert property (p_clear)
    else $error("clear ind wrong");
  a_notify: assert property (p_notify)
    else $error("no notify");
  a_notify_src: assert property (p_notify_src)
    else $error("bad notify");
endmodule

/* File: bench/fieldbus_node_status_control_tb.sv */
`timescale 1ns/1ps
module fieldbus_node_status_control_tb;
  import node_image_pkg::*;
  logic ref_clk = 0, rst = 1, slave_mode = 0, link_live = 0;
  logic valid_response = 0, ident_mismatch = 0, link_fault = 0;
  logic size_mismatch = 0, alarm_pending = 0, diag_pending = 0;
  logic clear_mode = 0, alarm_acked = 0, requester_is_cyclic = 1;
  logic svc_done = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic alarm_notify, svc_valid, svc_refused, irq, a;
  logic [NODE_W-1:0] actual_node = 8'h00;
  logic [CKSUM_W-1:0] computed_cksum = 16'h0000;
  logic [REQ_W-1:0] svc_data;
  logic [ACYC_CNT_W-1:0] queue_level;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  int failures = 0, n_compared = 0, n_notify = 0, n_refused = 0;
  node_image_if img();
  node_image_device i_node_image_device(.ref_clk, .rst, .img(img),
    .slave_mode, .link_live, .valid_response, .ident_mismatch, .link_fault,
    .size_mismatch, .alarm_pending, .diag_pending, .actual_node,
    .computed_cksum, .clear_mode, .alarm_acked, .requester_is_cyclic,
    .alarm_notify, .svc_valid, .svc_data, .svc_done, .svc_refused,
    .queue_level);
  node_image_host i_node_image_host(.ref_clk, .rst, .img(img), .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .irq);
  node_image_props i_node_image_props(.ref_clk, .rst, .slave_mode,
    .link_live, .valid_response, .ident_mismatch, .link_fault,
    .size_mismatch, .alarm_pending, .diag_pending, .clear_mode,
    .alarm_notify, .cyclic_link_live(img.cyclic_link_live),
    .node_fault_flag(img.node_fault_flag),
    .unloaded_alarm_waiting(img.unloaded_alarm_waiting),
    .diag_waiting_flag(img.diag_waiting_flag),
    .station_addr_conflict(img.station_addr_conflict),
    .clear_state_indicator(img.clear_state_indicator),
    .node_number(img.node_number), .ctrl_node_number(img.ctrl_node_number),
    .alarm_raise_request(img.alarm_raise_request));
  // clock and event counters
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (alarm_notify === 1'b1) n_notify++;
    if (svc_refused === 1'b1) n_refused++;
  end
  task check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task end_sim;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic av(input logic w, input logic [3:0] ad, input int d);
    int n = 0;
    avs_address <= ad;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // look at waitrequest mid cycle, so the completing edge is the next one
    do begin @(negedge ref_clk); n++; end
    while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata; // stands across the completing edge
    @(posedge ref_clk);
    avs_write <= 0;
    avs_read <= 0;
    if (n >= 100) begin failures++; end_sim(); end
    @(posedge ref_clk);
  endtask
  task t_status;
    av(0, REG_STATUS, 0); check("reset", rd, 32'hC0);
    link_live <= 1; alarm_pending <= 1; diag_pending <= 1;
    actual_node <= 8'h2A; computed_cksum <= 16'h1234;
    av(1, REG_CTRL, 32'h2A00); av(1, REG_CKSUM, 32'h1234);
    av(0, REG_STATUS, 0); check("st", rd, 32'h2ACD);
    av(0, REG_CKSUM, 0); check("sum", rd, 32'h1234);
    av(1, REG_CTRL, 32'h2B00); av(1, REG_CKSUM, 32'h1235);
    av(0, REG_STATUS, 0);
    check("cf", rd, 32'h2AFD);
    alarm_pending <= 0; diag_pending <= 0;
    av(1, REG_CTRL, 32'h2A00); av(1, REG_CKSUM, 32'h1234);
    av(0, REG_STATUS, 0); check("st2", rd, 32'h2AC1);
  endtask
  task t_fault;
    for (int k = 0; k < 3; k++) begin
      {size_mismatch, link_fault, ident_mismatch} <= 3'h1 << k;
      cyc(1); {size_mismatch, link_fault, ident_mismatch} <= 3'h0;
      av(0, REG_STATUS, 0); check("fset", rd[ST_FAULT], 1);
      valid_response <= 1; cyc(1); valid_response <= 0;
      av(0, REG_STATUS, 0); check("fclr", rd[ST_FAULT], 0);
    end
    av(0, REG_IRQ_STAT, 0); check("istat", rd[IRQ_FAULT], 1);
    av(1, REG_IRQ_MASK, 0); a = irq;
    av(1, REG_IRQ_MASK, 32'hF); check("mask", irq ^ a, 1);
    av(1, REG_IRQ_STAT, 32'hF); av(0, REG_IRQ_STAT, 0);
    check("iclr", rd[IRQ_W-1:0], 0); check("irq", irq, 0);
  endtask
  task t_slave;
    slave_mode <= 1; clear_mode <= 1; cyc(2);
    av(0, REG_STATUS, 0); check("clr", rd[ST_CLEAR], 0);
    clear_mode <= 0; n_notify = 0;
    av(1, REG_CTRL, 32'h2A01); av(1, REG_CTRL, 32'h2A01); cyc(3);
    check("notify", n_notify, 1);
    av(0, REG_STATUS, 0); check("ack0", rd[ST_ACK], 1);
    alarm_acked <= 1; cyc(1); alarm_acked <= 0;
    av(0, REG_STATUS, 0); check("ack1", rd[ST_ACK], 0);
    av(1, REG_CTRL, 32'h2A00); slave_mode <= 0;
  endtask
  task t_queue;
    for (int i = 1; i <= ACYC_DEPTH; i++) av(1, REG_REQ_DATA, i);
    cyc(2); check("level", queue_level, ACYC_DEPTH);
    check("full", img.req_ready, 0);
    for (int i = 1; i <= ACYC_DEPTH; i++) begin
      for (int n = 0; svc_valid !== 1'b1; n++) begin
        if (n > 50) begin failures++; end_sim(); end
        @(posedge ref_clk);
      end
      check("svc", svc_data, i);
      svc_done <= 1; cyc(1); svc_done <= 0; cyc(2);
    end
    check("empty", queue_level, 0);
    link_live <= 0; n_refused = 0; av(1, REG_REQ_DATA, 32'h55); cyc(4);
    check("ref1", n_refused, 1);
    link_live <= 1; requester_is_cyclic <= 0;
    av(1, REG_REQ_DATA, 32'h66); cyc(4);
    check("ref2", n_refused, 2);
    check("nosvc", svc_valid, 0);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    t_status;
    t_fault;
    t_slave;
    t_queue;
    end_sim;
  end
endmodule
